// ---- crctl_pkg.sv ----
// Shared constants and carriers for the cold-redundancy control block.
// Assumes one 125 MHz clock and a byte-command front end that delivers whole transactions.
package crctl_pkg;

    // ------------------------------------------------------------------
    // Command and transaction encoding
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_ROLE_SELECT = 8'hD0;
    localparam logic       RW_WRITE        = 1'b0;
    localparam logic       RW_READ         = 1'b1;
    localparam logic [7:0] PEC_POLY        = 8'h07;
    localparam logic [7:0] PEC_INIT        = 8'h00;
    localparam logic [2:0] PEC_LEN_WRITE   = 3'h3;
    localparam logic [2:0] PEC_LEN_READ    = 3'h4;

    // ------------------------------------------------------------------
    // Role codes held in the role select register
    // ------------------------------------------------------------------
    typedef enum logic [7:0] {
        ROLE_STANDARD  = 8'h00,
        ROLE_ACTIVE    = 8'h01,
        ROLE_STANDBY_1 = 8'h02,
        ROLE_STANDBY_2 = 8'h03,
        ROLE_STANDBY_3 = 8'h04,
        ROLE_ALWAYS_SB = 8'h05
    } crctl_role_t;

    localparam crctl_role_t ROLE_RESET = ROLE_STANDARD;

    // ------------------------------------------------------------------
    // Load-share scale and example thresholds in millivolts
    // ------------------------------------------------------------------
    localparam int LS_FULL_SCALE_MV = 8000;
    localparam int SB1_EN_MV        = 3200;
    localparam int SB1_DIS_MV       = 1440;
    localparam int SB2_EN_MV        = 5000;
    localparam int SB2_DIS_MV       = 3010;
    localparam int SB3_EN_MV        = 6700;
    localparam int SB3_DIS_MV       = 4520;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS     = 8000;
    localparam int WAKE_DEADLINE_NS  = 100000;
    localparam int WAKE_DEADLINE_CYC = (WAKE_DEADLINE_NS * 1000) / CLK_PERIOD_PS;
    localparam int WAKE_LATENCY_CYC  = 2;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic       read;
        logic [6:0] addr;
        logic [7:0] code;
        logic [7:0] data;
        logic [7:0] pec;
    } crctl_req_t;

    typedef struct packed {
        logic       valid;
        logic       ack;
        logic [7:0] data;
        logic [7:0] pec;
    } crctl_rsp_t;

endpackage

// ---- crctl_pec.sv ----
// Packet error code generator over up to four bytes, first byte at index 0.
// Assumes the caller presents all bytes at once and reads the result in the same cycle.
`timescale 1ns/1ps
module crctl_pec
(
    input  wire logic [3:0][7:0] bytes_in,
    input  wire logic [2:0]      nbytes,
    output logic      [7:0]      crc
);

    // ------------------------------------------------------------------
    // One byte of the CRC-8 update.
    // ------------------------------------------------------------------
    function automatic logic [7:0] crctl_pec_step(input logic [7:0] c_in, input logic [7:0] b);
        logic [7:0] c;
        c = c_in ^ b;
        for (int k = 0; k < 8; k++)
        begin
            c = c[7] ? ({c[6:0], 1'b0} ^ crctl_pkg::PEC_POLY) : {c[6:0], 1'b0};
        end
        return c;
    endfunction

    // ------------------------------------------------------------------
    // Byte walk.
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [7:0] c;
        c = crctl_pkg::PEC_INIT;
        for (int i = 0; i < 4; i++)
        begin
            if (3'(i) < nbytes)
            begin
                c = crctl_pec_step(c, bytes_in[i]);
            end
        end
        crc = c;
    end

endmodule

// ---- crctl_top.sv ----
// Cold-redundancy control: role register, wake bus drive and standby converter decision.
// Assumes a front end that hands in whole byte transactions and synchronous pin inputs.
//
// Behaviour
// R01: Pull the wake bus low on own fault or output below fault threshold.
// R02: A standby supply turns its converter on while the wake bus is low.
// R03: Without an active supply holding the bus high, every supply runs.
// R04: After reset every supply runs, before any role write takes effect.
// R05: Standby stays off only with bus high and load below wake level.
// R06: Standby watches load share with a threshold set by its position.
// R07: Position one turns on at 3.2 V and off at 1.44 V, tunable.
// R08: Position two turns on at 5.0 V and off at 3.01 V, tunable.
// R09: Position three turns on at 6.7 V and off at 4.52 V, tunable.
// R10: Load-share codes assume 8.0 V full scale at full rated power.
// R11: Standard and active roles keep the converter permanently on.
// R12: Active role drives bus high when healthy; others release; all pull low on fault.
// R13: Standby converters run within 100 us of the bus going low.
// R14: Role is read and written by command D0 with byte protocol and PEC.
// R15: Role codes: 00 standard, 01 active, 02 to 04 positions, 05 always standby.
// R16: Always-standby stays off unless forced by bus low or missing active driver.
// R17: A bus high-to-low edge reverts any standby role to standard.
// R18: Host must rewrite the role after a wake event to resume standby.
// R19: Standard role releases the bus when healthy, pulls it low on fault.
// R20: Standby turns on above enable level, off only below lower disable level.
`timescale 1ns/1ps
module crctl_top
#(
    parameter int         LS_W              = 10,
    parameter logic [6:0] DEV_ADDR          = 7'h58,
    parameter int         WAKE_DEADLINE_CYC = crctl_pkg::WAKE_DEADLINE_CYC,
    parameter int         SB1_EN_MV         = crctl_pkg::SB1_EN_MV,
    parameter int         SB1_DIS_MV        = crctl_pkg::SB1_DIS_MV,
    parameter int         SB2_EN_MV         = crctl_pkg::SB2_EN_MV,
    parameter int         SB2_DIS_MV        = crctl_pkg::SB2_DIS_MV,
    parameter int         SB3_EN_MV         = crctl_pkg::SB3_EN_MV,
    parameter int         SB3_DIS_MV        = crctl_pkg::SB3_DIS_MV
)
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire crctl_pkg::crctl_req_t req,
    output crctl_pkg::crctl_rsp_t      rsp,
    input  wire logic                  wake_i,
    output logic                       wake_o,
    output logic                       wake_oe_n,
    input  wire logic                  own_fault,
    input  wire logic                  vout_low,
    input  wire logic [LS_W-1:0]       load_share,
    output logic                       converter_on,
    output logic                       converter_active_n,
    output crctl_pkg::crctl_role_t     role
);

    // ------------------------------------------------------------------
    // Elaboration checks.
    // ------------------------------------------------------------------
    if (LS_W < 4 || LS_W > 16)
    begin : g_chk_width
        $error("Load-share width must lie between 4 and 16 bits.");
    end
    if (WAKE_DEADLINE_CYC < crctl_pkg::WAKE_LATENCY_CYC)
    begin : g_chk_deadline
        $error("Wake deadline is shorter than the wake path latency.");
    end
    if (SB1_DIS_MV >= SB1_EN_MV || SB2_DIS_MV >= SB2_EN_MV || SB3_DIS_MV >= SB3_EN_MV)
    begin : g_chk_hyst
        $error("Each disable threshold must lie below its enable threshold.");
    end
    if (SB1_EN_MV > crctl_pkg::LS_FULL_SCALE_MV || SB2_EN_MV > crctl_pkg::LS_FULL_SCALE_MV
        || SB3_EN_MV > crctl_pkg::LS_FULL_SCALE_MV)
    begin : g_chk_scale
        $error("Enable thresholds must not exceed the load-share full scale.");
    end

    // ------------------------------------------------------------------
    // Functions.
    // ------------------------------------------------------------------
    // Converts a level in millivolts to a load-share code.
    function automatic logic [LS_W-1:0] mv_to_code(input int mv);
        longint full;
        full = (longint'(1) << LS_W) - 1;
        return LS_W'((longint'(mv) * full) / crctl_pkg::LS_FULL_SCALE_MV); // [R10]
    endfunction

    // True for every role that may hold its converter off.
    function automatic logic is_standby(input crctl_pkg::crctl_role_t r);
        case (r)
            crctl_pkg::ROLE_STANDBY_1: return 1'b1;
            crctl_pkg::ROLE_STANDBY_2: return 1'b1;
            crctl_pkg::ROLE_STANDBY_3: return 1'b1;
            crctl_pkg::ROLE_ALWAYS_SB: return 1'b1;
            default:                   return 1'b0;
        endcase
    endfunction

    // True for a legal role code.
    function automatic logic is_role_code(input logic [7:0] v);
        return v <= 8'(crctl_pkg::ROLE_ALWAYS_SB); // [R15]
    endfunction

    // ------------------------------------------------------------------
    // Threshold codes.
    // ------------------------------------------------------------------
    localparam logic [LS_W-1:0] SB1_EN  = mv_to_code(SB1_EN_MV);  // [R07]
    localparam logic [LS_W-1:0] SB1_DIS = mv_to_code(SB1_DIS_MV); // [R07]
    localparam logic [LS_W-1:0] SB2_EN  = mv_to_code(SB2_EN_MV);  // [R08]
    localparam logic [LS_W-1:0] SB2_DIS = mv_to_code(SB2_DIS_MV); // [R08]
    localparam logic [LS_W-1:0] SB3_EN  = mv_to_code(SB3_EN_MV);  // [R09]
    localparam logic [LS_W-1:0] SB3_DIS = mv_to_code(SB3_DIS_MV); // [R09]

    // ------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------
    crctl_pkg::crctl_role_t role_q;
    crctl_pkg::crctl_role_t role_d;
    logic                   wake_prev_q;
    logic                   stby_run_q;
    logic                   stby_run_d;
    logic                   conv_on_q;
    logic                   conv_on_d;
    logic                   wake_o_q;
    logic                   wake_o_d;
    logic                   wake_oe_n_q;
    logic                   wake_oe_n_d;
    crctl_pkg::crctl_rsp_t  rsp_q;
    crctl_pkg::crctl_rsp_t  rsp_d;

    // ------------------------------------------------------------------
    // Transaction decode and PEC.
    // ------------------------------------------------------------------
    logic [7:0]      addr_w_byte;
    logic [7:0]      addr_r_byte;
    logic [3:0][7:0] wr_bytes;
    logic [3:0][7:0] rd_bytes;
    logic [7:0]      wr_pec;
    logic [7:0]      rd_pec;
    logic            req_mine;
    logic            code_hit;
    logic            wr_pec_ok;
    logic            wr_accept;
    logic            rd_accept;

    assign addr_w_byte = {DEV_ADDR, crctl_pkg::RW_WRITE};
    assign addr_r_byte = {DEV_ADDR, crctl_pkg::RW_READ};
    assign wr_bytes    = {8'h00, req.data, req.code, addr_w_byte};
    assign rd_bytes    = {8'(role_q), addr_r_byte, req.code, addr_w_byte};
    assign req_mine    = req.valid && (req.addr == DEV_ADDR);
    assign code_hit    = req.code == crctl_pkg::CMD_ROLE_SELECT;                 // [R14]
    assign wr_pec_ok   = req.pec == wr_pec;                                      // [R14]
    assign wr_accept   = req_mine && !req.read && code_hit && wr_pec_ok
                         && is_role_code(req.data);                            // [R14] [R15]
    assign rd_accept   = req_mine && req.read && code_hit;                       // [R14]

    crctl_pec u_pec_wr
    (
        .bytes_in (wr_bytes),
        .nbytes   (crctl_pkg::PEC_LEN_WRITE),
        .crc      (wr_pec)
    );

    crctl_pec u_pec_rd
    (
        .bytes_in (rd_bytes),
        .nbytes   (crctl_pkg::PEC_LEN_READ),
        .crc      (rd_pec)
    );

    // ------------------------------------------------------------------
    // Wake bus view and drive.
    // ------------------------------------------------------------------
    logic wake_fall;
    logic force_on;
    logic pull_low;
    logic drive_high;

    assign wake_fall  = wake_prev_q && !wake_i;                                  // [R17]
    assign force_on   = !wake_i;                                                 // [R02] [R03]
    assign pull_low   = own_fault || vout_low;                                   // [R01]
    assign drive_high = (role_q == crctl_pkg::ROLE_ACTIVE) && !pull_low;         // [R12]
    assign wake_o_d   = drive_high;                                              // [R12]
    assign wake_oe_n_d = !(pull_low || drive_high);                              // [R12] [R19]

    // ------------------------------------------------------------------
    // Role register.
    // ------------------------------------------------------------------
    logic revert_role;

    assign revert_role = wake_fall && is_standby(role_q);                        // [R17]

    // A wake edge on a standby role wins over a host write landing in the same cycle.
    assign role_d = revert_role ? crctl_pkg::ROLE_STANDARD                       // [R17]
                  : wr_accept   ? crctl_pkg::crctl_role_t'(req.data)             // [R14]
                  : role_q;

    // ------------------------------------------------------------------
    // Load-share thresholds and hysteresis.
    // ------------------------------------------------------------------
    logic [LS_W-1:0] en_code;
    logic [LS_W-1:0] dis_code;
    logic            load_wake_ok;
    logic            load_hi;
    logic            load_lo;

    assign en_code  = (role_q == crctl_pkg::ROLE_STANDBY_1) ? SB1_EN                  // [R06]
                    : (role_q == crctl_pkg::ROLE_STANDBY_2) ? SB2_EN
                    : SB3_EN;
    assign dis_code = (role_q == crctl_pkg::ROLE_STANDBY_1) ? SB1_DIS                 // [R06]
                    : (role_q == crctl_pkg::ROLE_STANDBY_2) ? SB2_DIS
                    : SB3_DIS;
    assign load_wake_ok = is_standby(role_q) && (role_q != crctl_pkg::ROLE_ALWAYS_SB); // [R16]
    assign load_hi  = load_share > en_code;                                           // [R20]
    assign load_lo  = load_share < dis_code;                                          // [R20]
    assign stby_run_d = load_wake_ok && (load_hi || (stby_run_q && !load_lo));        // [R05] [R20]

    // ------------------------------------------------------------------
    // Converter decision.
    // ------------------------------------------------------------------
    // Non-standby roles run unconditionally; standby runs when forced, or when loaded in positions one to three (always-standby ignores load).
    assign conv_on_d = !is_standby(role_q)                                        // [R11]
                     || force_on                                                  // [R02] [R13]
                     || stby_run_d;                                               // [R05]

    // ------------------------------------------------------------------
    // Answer to the front end.
    // ------------------------------------------------------------------
    always_comb
    begin
        rsp_d       = '0;
        rsp_d.valid = req_mine;
        rsp_d.ack   = wr_accept || rd_accept;
        rsp_d.data  = rd_accept ? 8'(role_q) : 8'h00;
        rsp_d.pec   = rd_accept ? rd_pec : 8'h00;                                 // [R14]
    end

    // ------------------------------------------------------------------
    // Registers.
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            role_q      <= crctl_pkg::ROLE_RESET;                                 // [R04] [R15]
            wake_prev_q <= 1'b0;
            stby_run_q  <= 1'b0;
            conv_on_q   <= 1'b1;                                                  // [R04]
        end
        else
        begin
            role_q      <= role_d;
            wake_prev_q <= wake_i;
            stby_run_q  <= stby_run_d;
            conv_on_q   <= conv_on_d;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wake_o_q    <= 1'b0;
            wake_oe_n_q <= 1'b1;
            rsp_q       <= '0;
        end
        else
        begin
            wake_o_q    <= wake_o_d;
            wake_oe_n_q <= wake_oe_n_d;
            rsp_q       <= rsp_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------
    assign converter_on       = conv_on_q;
    assign converter_active_n = !conv_on_q;                                       // [R05]
    assign wake_o             = wake_o_q;
    assign wake_oe_n          = wake_oe_n_q;
    assign rsp                = rsp_q;
    assign role               = role_q;

endmodule

// ---- crctl_sva.sv ----
// Concurrent checks on the ports of the cold-redundancy control block.
// Assumes it is bound onto crctl_top with the same parameters.
`timescale 1ns/1ps
module crctl_sva
#(
    parameter int         LS_W     = 10,
    parameter logic [6:0] DEV_ADDR = 7'h58
)
(
    input wire logic                   sys_clk,
    input wire logic                   rst,
    input wire crctl_pkg::crctl_req_t  req,
    input wire crctl_pkg::crctl_rsp_t  rsp,
    input wire logic                   wake_i,
    input wire logic                   wake_o,
    input wire logic                   wake_oe_n,
    input wire logic                   own_fault,
    input wire logic                   vout_low,
    input wire logic [LS_W-1:0]        load_share,
    input wire logic                   converter_on,
    input wire logic                   converter_active_n,
    input wire crctl_pkg::crctl_role_t role
);
    // ------------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire logic hit = req.valid && req.addr == DEV_ADDR;
    wire logic ok  = !own_fault && !vout_low;

    a_fault_pull_low: assert property ((own_fault || vout_low) |=> !wake_oe_n && !wake_o)
        else $error("wake bus not pulled low on fault");
    a_active_high: assert property (role == crctl_pkg::ROLE_ACTIVE && ok
        ##1 role == crctl_pkg::ROLE_ACTIVE |-> !wake_oe_n && wake_o)
        else $error("active role does not drive bus high");
    a_healthy_release: assert property (role != crctl_pkg::ROLE_ACTIVE && ok
        ##1 role != crctl_pkg::ROLE_ACTIVE |-> wake_oe_n)
        else $error("bus not released while healthy");
    a_bus_low_wake: assert property (!wake_i |=> converter_on)
        else $error("converter off while wake bus low");
    a_plain_on: assert property (role <= crctl_pkg::ROLE_ACTIVE
        ##1 role <= crctl_pkg::ROLE_ACTIVE |-> converter_on)
        else $error("converter off in standard or active role");
    a_active_n_inv: assert property (converter_active_n == !converter_on)
        else $error("converter active output not inverse of run state");
    a_always_sb_off: assert property (role == crctl_pkg::ROLE_ALWAYS_SB && wake_i
        ##1 role == crctl_pkg::ROLE_ALWAYS_SB |-> !converter_on)
        else $error("always standby converter running");
    a_edge_revert: assert property ($past(wake_i) && !wake_i
        && role >= crctl_pkg::ROLE_STANDBY_1 |=> role == crctl_pkg::ROLE_STANDARD)
        else $error("standby role kept after wake edge");
    a_rsp_next: assert property (hit |=> rsp.valid)
        else $error("no answer one cycle after request");
    a_rsp_none: assert property (!hit |=> !rsp.valid)
        else $error("answer without request");
    a_bad_code: assert property (hit && req.code != crctl_pkg::CMD_ROLE_SELECT
        |=> !rsp.ack)
        else $error("unknown command accepted");
    a_role_legal: assert property (role <= crctl_pkg::ROLE_ALWAYS_SB)
        else $error("role register holds undefined code");
endmodule

bind crctl_top crctl_sva #(.LS_W(LS_W), .DEV_ADDR(DEV_ADDR)) u_sva
(
    .sys_clk(sys_clk), .rst(rst), .req(req), .rsp(rsp), .wake_i(wake_i),
    .wake_o(wake_o), .wake_oe_n(wake_oe_n), .own_fault(own_fault),
    .vout_low(vout_low), .load_share(load_share), .converter_on(converter_on),
    .converter_active_n(converter_active_n), .role(role)
);

// ---- crctl_peer_model.sv ----
// Peer supplies on the shared wake bus and the resolved wire level.
// Assumes no pull-up on the bus, so an undriven bus reads low.
`timescale 1ns/1ps
module crctl_peer_model
(
    input  wire logic dut_o,
    input  wire logic dut_oe_n,
    input  wire logic peer_hi,
    input  wire logic peer_low,
    output logic      bus
);
    // ------------------------------------------------------------------
    // Wire resolution
    // ------------------------------------------------------------------
    wire logic pull_low = (!dut_oe_n && !dut_o) || peer_low;
    wire logic drive_hi = (!dut_oe_n && dut_o) || peer_hi;
    assign bus = !pull_low && drive_hi;
endmodule

// ---- test_cold_redundancy_control.sv ----
// Self-checking bench for the cold-redundancy control block.
// Assumes the peer model resolves the wake bus fed back to the design.
`timescale 1ns/1ps
module test_cold_redundancy_control;
    // ------------------------------------------------------------------
    // Constants and signals
    // ------------------------------------------------------------------
    localparam logic [6:0] ADR = 7'h58;
    localparam logic [7:0] CMD = crctl_pkg::CMD_ROLE_SELECT;
    localparam logic [7:0] S0 = 8'h00, S1 = 8'h01, S2 = 8'h02, S3 = 8'h03, S4 = 8'h04, S5 = 8'h05;
    localparam logic [1:0] REL = 2'h2, HI = 2'h1, LO = 2'h0;
    localparam int FS = 10'h3FF;
    localparam int SC = crctl_pkg::LS_FULL_SCALE_MV;
    localparam int E1 = crctl_pkg::SB1_EN_MV * FS / SC, D1 = crctl_pkg::SB1_DIS_MV * FS / SC;
    localparam int E2 = crctl_pkg::SB2_EN_MV * FS / SC, D2 = crctl_pkg::SB2_DIS_MV * FS / SC;
    localparam int E3 = crctl_pkg::SB3_EN_MV * FS / SC, D3 = crctl_pkg::SB3_DIS_MV * FS / SC;
    typedef struct packed {
        logic [7:0] r, er;
        logic       act;
        logic [1:0] flt;
        logic [9:0] ls;
        logic       on;
        logic [1:0] dr;
    } crctl_row_t;
    logic                   sys_clk = 1'b0, rst = 1'b1, own_fault = 1'b0, vout_low = 1'b0;
    logic                   peer_hi = 1'b0, peer_low = 1'b0;
    logic [9:0]             load_share = 10'h000;
    crctl_pkg::crctl_req_t  req = '0;
    crctl_pkg::crctl_rsp_t  rsp;
    logic                   wake_i, wake_o, wake_oe_n, converter_on, converter_active_n;
    crctl_pkg::crctl_role_t role;
    crctl_row_t             rows[$];
    int                     bad_count = 0, samples_checked = 0, cycles = 0;
    wire logic [11:0] lvl = {role, converter_on, converter_active_n, wake_oe_n,
                             wake_o & ~wake_oe_n};

    crctl_top #(.WAKE_DEADLINE_CYC(4)) dut (.sys_clk(sys_clk), .rst(rst), .req(req), .rsp(rsp),
        .wake_i(wake_i), .wake_o(wake_o), .wake_oe_n(wake_oe_n), .own_fault(own_fault),
        .vout_low(vout_low), .load_share(load_share), .converter_on(converter_on),
        .converter_active_n(converter_active_n), .role(role));
    crctl_peer_model peer (.dut_o(wake_o), .dut_oe_n(wake_oe_n), .peer_hi(peer_hi),
        .peer_low(peer_low), .bus(wake_i));

    always #4 sys_clk = ~sys_clk;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] crc8(input logic [31:0] b, input int n);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < n; i++)
        begin
            c = c ^ b[31 - 8 * i -: 8];
            for (int j = 0; j < 8; j++)
                c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
        end
        return c;
    endfunction
    function automatic logic [11:0] ex(input logic [7:0] r, input logic on, input logic [1:0] dr);
        return {r, on, ~on, dr};
    endfunction
    task automatic summarize();
        if (bad_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk_rsp(input crctl_pkg::crctl_rsp_t got, input crctl_pkg::crctl_rsp_t exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_lvl(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input crctl_pkg::crctl_req_t q, input crctl_pkg::crctl_rsp_t e);
        @(negedge sys_clk);
        req = q;
        @(negedge sys_clk);
        req.valid = 1'b0;
        chk_rsp(rsp, e);
    endtask
    task automatic wr(input logic [7:0] c, d, bad, input logic a);
        xfer('{1'b1, 1'b0, ADR, c, d, crc8({ADR, 1'b0, c, d, 8'h00}, 3) ^ bad},
             '{1'b1, a, 8'h00, 8'h00});
    endtask
    task automatic rd(input logic [7:0] r);
        xfer('{1'b1, 1'b1, ADR, CMD, 8'h00, 8'h00},
             '{1'b1, 1'b1, r, crc8({ADR, 1'b0, CMD, ADR, 1'b1, r}, 4)});
    endtask
    task automatic add(input logic [7:0] r, er, input logic a, input logic [1:0] f, input int ls,
                       input logic on, input logic [1:0] dr);
        rows.push_back('{r, er, a, f, 10'(ls), on, dr});
    endtask

    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            bad_count++;
            summarize();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        add(S0, S0, 1, 0, 0, 1, REL);
        add(S1, S1, 0, 0, 0, 1, HI);
        add(S1, S1, 0, 1, 0, 1, LO);
        add(S2, S2, 1, 0, 0, 0, REL);
        add(S2, S2, 1, 0, E1, 0, REL);
        add(S2, S2, 1, 0, E1 + 1, 1, REL);
        add(S2, S2, 1, 0, D1, 1, REL);
        add(S2, S2, 1, 0, D1 - 1, 0, REL);
        add(S3, S3, 1, 0, E2, 0, REL);
        add(S3, S3, 1, 0, E2 + 1, 1, REL);
        add(S3, S3, 1, 0, D2, 1, REL);
        add(S3, S3, 1, 0, D2 - 1, 0, REL);
        add(S4, S4, 1, 0, E3, 0, REL);
        add(S4, S4, 1, 0, E3 + 1, 1, REL);
        add(S4, S4, 1, 0, D3, 1, REL);
        add(S4, S4, 1, 0, D3 - 1, 0, REL);
        add(S5, S5, 1, 0, FS, 0, REL);
        add(S2, S0, 1, 1, 0, 1, LO);
        add(S3, S3, 1, 2, 0, 1, LO);
        add(S2, S2, 0, 0, 0, 1, REL);
        repeat (10) @(negedge sys_clk);
        chk_lvl(lvl, ex(S0, 1'b1, REL));
        chk_rsp(rsp, '0);
        rst = 1'b0;
        foreach (rows[i])
        begin
            wr(CMD, rows[i].r, 8'h00, 1'b1);
            peer_hi = rows[i].act;
            {vout_low, own_fault} = rows[i].flt;
            load_share = rows[i].ls;
            repeat (3) @(negedge sys_clk);
            chk_lvl(lvl, ex(rows[i].er, rows[i].on, rows[i].dr));
        end
        rd(S2);
        peer_hi = 1'b1;
        repeat (3) @(negedge sys_clk);
        chk_lvl(lvl, ex(S2, 1'b0, REL));
        peer_low = 1'b1;
        @(negedge sys_clk);
        chk_lvl(lvl, ex(S0, 1'b1, REL));
        peer_low = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk_lvl(lvl, ex(S0, 1'b1, REL));
        wr(8'hD1, S2, 8'h00, 1'b0);
        wr(CMD, 8'h06, 8'h00, 1'b0);
        wr(CMD, S2, 8'h01, 1'b0);
        xfer('{1'b1, 1'b0, ADR ^ 7'h01, CMD, S2, 8'h00}, '0);
        rd(S0);
        wr(CMD, S5, 8'h00, 1'b1);
        repeat (2) @(negedge sys_clk);
        chk_lvl(lvl, ex(S5, 1'b0, REL));
        rst = 1'b1;
        @(negedge sys_clk);
        chk_lvl(lvl, ex(S0, 1'b1, REL));
        rst = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk_lvl(lvl, ex(S0, 1'b1, REL));
        summarize();
    end
endmodule
